// >>> verilog/wbo_pkg.sv
`default_nettype none

package wbo_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WORD_ADD   = 8'h1D;
  localparam logic [7:0] OP_WORD_SUB   = 8'h3D;
  localparam logic [7:0] OP_WORD_CMP   = 8'h5D;
  localparam logic [7:0] OP_WORD_DEC   = 8'hBD;
  localparam logic [7:0] OP_WORD_INC   = 8'h9D;
  localparam logic [7:0] OP_WORD_LOAD  = 8'h7D;
  localparam logic [7:0] OP_WORD_STORE = 8'hDD;
  localparam logic [7:0] OP_CARRY_AND  = 8'h8B;
  localparam logic [7:0] OP_CARRY_OR   = 8'h6B;
  localparam logic [7:0] OP_CARRY_XOR  = 8'hAB;
  localparam logic [7:0] OP_CARRY_LOAD = 8'hCB;
  localparam logic [7:0] OP_CARRY_STOR = 8'hEB;
  localparam logic [7:0] OP_MBIT_INV   = 8'h4B;
  localparam logic [7:0] OP_BIT_PAGE   = 8'h0C;
  localparam logic [7:0] OP_BIT_ABS    = 8'h1C;
  localparam logic [7:0] OP_ACC_CLR    = 8'h2B;
  localparam logic [7:0] OP_ACC_SET    = 8'h0B;
  localparam logic [7:0] OP_CARRY_CLR  = 8'h20;
  localparam logic [7:0] OP_CARRY_SET  = 8'hA0;
  localparam logic [7:0] OP_PAGE_CLR   = 8'h40;
  localparam logic [7:0] OP_PAGE_SET   = 8'hC0;
  localparam logic [7:0] OP_OVF_CLR    = 8'h80;
  localparam logic [7:0] OP_TEST_CLR   = 8'h5C;
  localparam logic [7:0] OP_TEST_SET   = 8'h3C;
  localparam logic [3:0] DPBIT_NIBBLE  = 4'h1;

  // ----------------------------------------------------------------
  // cycle counts
  // ----------------------------------------------------------------
  localparam logic [3:0] CYC_WORD_ALU  = 4'h5;
  localparam logic [3:0] CYC_WORD_CMP  = 4'h4;
  localparam logic [3:0] CYC_WORD_STEP = 4'h6;
  localparam logic [3:0] CYC_CARRY_SH  = 4'h4;
  localparam logic [3:0] CYC_CARRY_LG  = 4'h5;
  localparam logic [3:0] CYC_CARRY_ST  = 4'h6;
  localparam logic [3:0] CYC_BIT_PAGE  = 4'h4;
  localparam logic [3:0] CYC_BIT_ABS   = 4'h5;
  localparam logic [3:0] CYC_PAGE_BIT  = 4'h4;
  localparam logic [3:0] CYC_SHORT     = 4'h2;
  localparam logic [3:0] CYC_TEST_MOD  = 4'h6;
  localparam logic [3:0] CYC_ILLEGAL   = 4'h1;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MBIT_LSB     = 5;
  localparam int MBIT_INV     = 4;
  localparam int MADDR_HI_MSB = 3;
  localparam int DPBIT_LSB    = 5;
  localparam int DPBIT_CLR    = 4;
  localparam int ABIT_LSB     = 0;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] Y_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WBO_IDLE = 2'b01,
    WBO_EXEC = 2'b10
  } wbo_state_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
  } wbo_instr_s;

  typedef struct packed {
    logic n;
    logic v;
    logic g;
    logic b;
    logic h;
    logic i;
    logic z;
    logic c;
  } wbo_psw_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } wbo_mem_s;

endpackage

`default_nettype wire

// >>> verilog/wbo_exec.sv
// Overview of operation
// - word_add adds memory pair into pair register
// - word_subtract subtracts memory pair, writes difference
// - word_compare sets N Z C, keeps register
// - word_decrement decrements memory pair, sets N Z
// - word_increment increments memory pair, sets N Z
// - word_load loads pair register, high byte upper
// - word_store writes pair, upper to higher address
// - carry ANDed with plain or inverted bit
// - carry ORed with plain or inverted bit
// - carry XORed with plain or inverted bit
// - carry loaded from plain or inverted bit
// - bit test sets Z, N, V
// - direct-page bit clear or set, flags kept
// - accumulator bit clear or set, two cycles
// - carry_clear and carry_set in two cycles
// - page flag clear and set in two cycles
// - overflow_clear clears V in two cycles
// - memory_bit_invert flips bit, flags kept
// - carry_store_bit writes carry into memory bit
// - test_and_clear_bits: flags from A-M, clear bits
// - test_and_set_bits: flags from A-M, OR bits
`default_nettype none

module wbo_exec
  import wbo_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_start,
  input  wire wbo_instr_s i_instr,
  input  wire logic [7:0] i_mem_rdata,
  output logic            o_ready,
  output logic            o_done,
  output logic            o_illegal,
  output wbo_mem_s        o_mem,
  output logic [7:0]      o_acc,
  output logic [7:0]      o_yreg,
  output wbo_psw_s        o_psw
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] op_cycles(input logic [7:0] op);
    logic [3:0] c;
    c = (op[3:0] == DPBIT_NIBBLE) ? CYC_PAGE_BIT : CYC_ILLEGAL;
    case (op)
      OP_WORD_ADD, OP_WORD_SUB, OP_WORD_LOAD,
      OP_WORD_STORE:                c = CYC_WORD_ALU;
      OP_WORD_CMP:                  c = CYC_WORD_CMP;
      OP_WORD_DEC, OP_WORD_INC:     c = CYC_WORD_STEP;
      OP_CARRY_AND, OP_CARRY_LOAD:  c = CYC_CARRY_SH;
      OP_CARRY_OR, OP_CARRY_XOR,
      OP_MBIT_INV:                  c = CYC_CARRY_LG;
      OP_CARRY_STOR:                c = CYC_CARRY_ST;
      OP_BIT_PAGE:                  c = CYC_BIT_PAGE;
      OP_BIT_ABS:                   c = CYC_BIT_ABS;
      OP_ACC_CLR, OP_ACC_SET, OP_CARRY_CLR, OP_CARRY_SET,
      OP_PAGE_CLR, OP_PAGE_SET, OP_OVF_CLR: c = CYC_SHORT;
      OP_TEST_CLR, OP_TEST_SET:     c = CYC_TEST_MOD;
      default: ;
    endcase
    return c;
  endfunction

  function automatic logic is_word_read(input logic [7:0] op);
    return op inside {OP_WORD_ADD, OP_WORD_SUB, OP_WORD_CMP,
                      OP_WORD_DEC, OP_WORD_INC, OP_WORD_LOAD};
  endfunction

  function automatic logic is_mbit(input logic [7:0] op);
    return op inside {OP_CARRY_AND, OP_CARRY_OR, OP_CARRY_XOR,
                      OP_CARRY_LOAD, OP_CARRY_STOR, OP_MBIT_INV};
  endfunction

  function automatic logic is_byte_rmw(input logic [7:0] op);
    return (op[3:0] == DPBIT_NIBBLE) ||
           (op inside {OP_MBIT_INV, OP_CARRY_STOR,
                       OP_TEST_CLR, OP_TEST_SET});
  endfunction

  function automatic logic reads_mem(input logic [7:0] op);
    return is_word_read(op) || is_mbit(op) || is_byte_rmw(op) ||
           (op inside {OP_BIT_PAGE, OP_BIT_ABS});
  endfunction

  // direct page follows the page flag; M.bit carries a 12-bit address
  function automatic logic [15:0] base_addr(input wbo_instr_s ins,
                                            input logic       g);
    logic [15:0] a;
    a = {7'h00, g, ins.op1};
    if (ins.opcode inside {OP_BIT_ABS, OP_TEST_CLR, OP_TEST_SET})
      a = {ins.op2, ins.op1};
    else if (is_mbit(ins.opcode))
      a = {4'h0, ins.op2[MADDR_HI_MSB:0], ins.op1};
    return a;
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  wbo_state_e state;
  wbo_instr_s ins;
  logic [3:0] k;
  logic       last;
  logic       accept;
  logic [7:0] lo;
  logic [7:0] hi;

  assign o_ready   = (state == WBO_IDLE);
  assign accept    = o_ready && i_start;
  assign last      = (k == op_cycles(ins.opcode) - 4'h1);
  assign o_done    = (state == WBO_EXEC) && last;
  assign o_illegal = o_done && (op_cycles(ins.opcode) == CYC_ILLEGAL);

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= WBO_IDLE;
      k     <= 4'h0;
      ins   <= '0;
    end
    else
    begin
      unique case (state)
        WBO_IDLE:
          if (i_start)
          begin
            state <= WBO_EXEC;
            k     <= 4'h0;
            ins   <= i_instr;
          end
        WBO_EXEC:
          if (last)
            state <= WBO_IDLE;
          else
            k <= k + 4'h1;
        default: state <= WBO_IDLE;
      endcase
    end
  end

  // read data comes back one cycle after its request
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lo <= 8'h00;
      hi <= 8'h00;
    end
    else if (state == WBO_EXEC)
    begin
      if (k == 4'h1)
        lo <= i_mem_rdata;
      if (k == 4'h2)
        hi <= i_mem_rdata;
    end
  end

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  logic [15:0] mword;
  logic [15:0] pair;
  logic [16:0] sum;
  logic [16:0] dif;
  logic [12:0] hsum;
  logic [15:0] step;
  logic [7:0]  tdif;
  logic        mbit;
  logic [7:0]  mmask;
  logic [7:0]  dmask;
  logic [7:0]  amask;
  logic [7:0]  rmw;

  always_comb
  begin
    mword = {hi, lo};
    pair  = {o_yreg, o_acc};
    sum   = {1'b0, pair} + {1'b0, mword};
    dif   = {1'b0, pair} - {1'b0, mword};
    hsum  = {1'b0, pair[11:0]} + {1'b0, mword[11:0]};
    step  = (ins.opcode == OP_WORD_DEC) ? mword - 16'h0001
                                        : mword + 16'h0001;
    tdif  = o_acc - lo;
    mbit  = lo[ins.op2[MBIT_LSB +: 3]] ^ ins.op2[MBIT_INV];
    mmask = 8'h01 << ins.op2[MBIT_LSB +: 3];
    dmask = 8'h01 << ins.opcode[DPBIT_LSB +: 3];
    amask = 8'h01 << ins.op1[ABIT_LSB +: 3];
    rmw   = lo;
    if (ins.opcode[3:0] == DPBIT_NIBBLE)
      rmw = ins.opcode[DPBIT_CLR] ? (lo & ~dmask) : (lo | dmask);
    case (ins.opcode)
      OP_MBIT_INV:   rmw = lo ^ mmask;
      OP_CARRY_STOR: rmw = o_psw.c ? (lo | mmask) : (lo & ~mmask);
      OP_TEST_CLR:   rmw = lo & ~o_acc;
      OP_TEST_SET:   rmw = lo | o_acc;
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // memory requests, registered one cycle ahead of their slot
  // ----------------------------------------------------------------
  wbo_mem_s   next_mem;
  wbo_instr_s nin;
  logic [3:0] kk;
  logic [3:0] nlast;
  logic [15:0] base;

  always_comb
  begin
    kk       = accept ? 4'h0 : k + 4'h1;
    nin      = accept ? i_instr : ins;
    nlast    = op_cycles(nin.opcode) - 4'h1;
    base     = base_addr(nin, o_psw.g);
    next_mem = '0;
    if (accept || (state == WBO_EXEC && !last))
    begin
      next_mem.addr = base;
      if (reads_mem(nin.opcode) && kk == 4'h0)
        next_mem.rd = 1'b1;
      if (kk == 4'h1 && (is_word_read(nin.opcode) ||
          nin.opcode == OP_WORD_STORE))
        next_mem.addr = {base[15:8], base[7:0] + 8'h01};
      if (is_word_read(nin.opcode) && kk == 4'h1)
        next_mem.rd = 1'b1;
      if (nin.opcode == OP_WORD_STORE && kk < 4'h2)
      begin
        next_mem.wr    = 1'b1;
        next_mem.wdata = (kk == 4'h0) ? o_acc : o_yreg;
      end
      if ((nin.opcode inside {OP_WORD_DEC, OP_WORD_INC}) &&
          kk >= nlast - 4'h1)
      begin
        next_mem.wr    = 1'b1;
        next_mem.wdata = (kk == nlast) ? step[15:8] : step[7:0];
        if (kk == nlast)
          next_mem.addr = {base[15:8], base[7:0] + 8'h01};
      end
      if (is_byte_rmw(nin.opcode) && kk == nlast)
      begin
        next_mem.wr    = 1'b1;
        next_mem.wdata = rmw;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_mem <= '0;
    else
      o_mem <= next_mem;
  end

  // ----------------------------------------------------------------
  // register and flag commit at the last cycle
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_psw  <= PSW_RESET;
      o_acc  <= ACC_RESET;
      o_yreg <= Y_RESET;
    end
    else if (o_done)
    begin
      case (ins.opcode)
        OP_WORD_ADD:
        begin
          {o_yreg, o_acc} <= sum[15:0];
          o_psw.n <= sum[15];
          o_psw.v <= (pair[15] == mword[15]) && (sum[15] != pair[15]);
          o_psw.h <= hsum[12];
          o_psw.z <= (sum[15:0] == 16'h0000);
          o_psw.c <= sum[16];
        end
        OP_WORD_SUB:
        begin
          {o_yreg, o_acc} <= dif[15:0];
          o_psw.n <= dif[15];
          o_psw.v <= (pair[15] != mword[15]) && (dif[15] != pair[15]);
          o_psw.h <= (pair[11:0] >= mword[11:0]);
          o_psw.z <= (dif[15:0] == 16'h0000);
          o_psw.c <= !dif[16];
        end
        OP_WORD_CMP:
        begin
          o_psw.n <= dif[15];
          o_psw.z <= (dif[15:0] == 16'h0000);
          o_psw.c <= !dif[16];
        end
        OP_WORD_DEC, OP_WORD_INC:
        begin
          o_psw.n <= step[15];
          o_psw.z <= (step == 16'h0000);
        end
        OP_WORD_LOAD:
        begin
          {o_yreg, o_acc} <= mword;
          o_psw.n <= hi[7];
          o_psw.z <= (mword == 16'h0000);
        end
        OP_CARRY_AND:  o_psw.c <= o_psw.c & mbit;
        OP_CARRY_OR:   o_psw.c <= o_psw.c | mbit;
        OP_CARRY_XOR:  o_psw.c <= o_psw.c ^ mbit;
        OP_CARRY_LOAD: o_psw.c <= mbit;
        OP_BIT_PAGE, OP_BIT_ABS:
        begin
          o_psw.z <= ((o_acc & lo) == 8'h00);
          o_psw.n <= lo[7];
          o_psw.v <= lo[6];
        end
        OP_ACC_CLR:    o_acc   <= o_acc & ~amask;
        OP_ACC_SET:    o_acc   <= o_acc | amask;
        OP_CARRY_CLR:  o_psw.c <= 1'b0;
        OP_CARRY_SET:  o_psw.c <= 1'b1;
        OP_PAGE_CLR:   o_psw.g <= 1'b0;
        OP_PAGE_SET:   o_psw.g <= 1'b1;
        OP_OVF_CLR:    o_psw.v <= 1'b0;
        OP_TEST_CLR, OP_TEST_SET:
        begin
          o_psw.n <= tdif[7];
          o_psw.z <= (tdif == 8'h00);
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_five_span;
    !o_done [*4] ##1 o_done;
  endsequence

  sequence s_store_pair;
    o_mem.wr && o_mem.wdata == $past(o_acc)
    ##1 o_mem.wr && o_mem.wdata == $past(o_yreg, 2) &&
        o_mem.addr[7:0] == $past(o_mem.addr[7:0]) + 8'h01;
  endsequence

  word_add_span_a: assert property (
    accept && i_instr.opcode == OP_WORD_ADD |=> s_five_span)
    else $error("word add did not take five cycles");

  word_sub_res_a: assert property (
    o_done && ins.opcode == OP_WORD_SUB |=>
      {o_yreg, o_acc} == $past(dif[15:0]) && o_psw.c == !$past(dif[16]))
    else $error("word subtract result or carry wrong");

  word_cmp_keep_a: assert property (
    o_done && ins.opcode == OP_WORD_CMP |=>
      $stable({o_yreg, o_acc}) && $stable(o_psw.v) && $stable(o_psw.h))
    else $error("word compare altered register or V/H");

  word_inc_wr_a: assert property (
    o_done && ins.opcode == OP_WORD_INC |->
      o_mem.wr && o_mem.wdata == step[15:8] &&
      $past(o_mem.wr) && $past(o_mem.wdata) == step[7:0])
    else $error("word increment write-back wrong");

  word_store_a: assert property (
    accept && i_instr.opcode == OP_WORD_STORE |=> s_store_pair)
    else $error("word store bytes wrong");

  carry_and_a: assert property (
    o_done && ins.opcode == OP_CARRY_AND |=>
      o_psw.c == ($past(o_psw.c) & $past(mbit)) &&
      o_psw[7:1] == $past(o_psw[7:1]))
    else $error("carry and result or other flags wrong");

  bit_test_a: assert property (
    o_done && ins.opcode == OP_BIT_PAGE |=>
      o_psw.n == $past(lo[7]) && o_psw.v == $past(lo[6]))
    else $error("bit test N or V wrong");

  carry_clear_a: assert property (
    accept && i_instr.opcode == OP_CARRY_CLR |=> ##1 o_done ##1 !o_psw.c)
    else $error("carry clear timing or value wrong");

endmodule

`default_nettype wire

// >>> bench/wbo_mem_model.sv
`default_nettype none

module wbo_mem_model
  import wbo_pkg::*;
(
  input  wire logic     i_clk,
  input  wire wbo_mem_s i_mem,
  output logic [7:0]    o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------
  // storage
  // ----------------------------
  // plain always: the bench preloads cells by hierarchy
  logic [7:0] mem [0:65535];
  logic [7:0] rdata_q = 8'h00;

  always @(posedge i_clk)
  begin
    if (i_mem.wr)
      mem[i_mem.addr] <= i_mem.wdata;
  end

  // ----------------------------
  // read port
  // ----------------------------
  // data is valid only in the cycle after rd; otherwise the bus toggles
  // so a late sample cannot match by luck
  always @(posedge i_clk)
  begin
    if (i_mem.rd)
      rdata_q <= mem[i_mem.addr];
    else
      rdata_q <= ~rdata_q;
  end

  assign o_rdata = rdata_q;
endmodule

`default_nettype wire

// >>> bench/wbo_exec_tb.sv
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("BAD %s expected %0h seen %0h", nm, e, g); \
    end \
  end

module wbo_exec_tb
  import wbo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------
  // signals
  // ----------------------------
  typedef struct packed {
    logic [23:0] ins;
    logic [3:0]  n;
    logic [15:0] pa;
    logic [7:0]  p0;
    logic [7:0]  p1;
    logic [7:0]  ea;
    logic [7:0]  ey;
    logic [7:0]  ep;
    logic [7:0]  e0;
    logic [7:0]  e1;
  } wbo_row_s;

  logic       i_clk       = 1'b0;
  logic       i_nrst      = 1'b0;
  logic       i_start     = 1'b0;
  wbo_instr_s i_instr     = '0;
  logic [7:0] mem_rdata;
  logic       o_ready;
  logic       o_done;
  logic       o_illegal;
  wbo_mem_s   o_mem;
  logic [7:0] o_acc;
  logic [7:0] o_yreg;
  wbo_psw_s   o_psw;
  int         checked     = 0;
  int         miscompares = 0;

  always #50 i_clk = ~i_clk;

  wbo_exec i_dut (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_start     (i_start),
    .i_instr     (i_instr),
    .i_mem_rdata (mem_rdata),
    .o_ready     (o_ready),
    .o_done      (o_done),
    .o_illegal   (o_illegal),
    .o_mem       (o_mem),
    .o_acc       (o_acc),
    .o_yreg      (o_yreg),
    .o_psw       (o_psw)
  );

  wbo_mem_model i_mem (
    .i_clk   (i_clk),
    .i_mem   (o_mem),
    .o_rdata (mem_rdata)
  );

  // ----------------------------
  // rows: instr, cycles, addr, preload, A, Y, psw, memory after
  // ----------------------------
  // state carries from row to row, so each row starts where the last ended
  wbo_row_s rows [35] = '{
    100'h7D1000_5_0010_3492_34_92_80_3492,
    100'h1D2000_5_0020_CC6D_00_00_0B_CC6D,
    100'h3D3000_5_0030_0100_FF_FF_80_0100,
    100'h0C5000_4_0050_4000_FF_FF_40_4000,
    100'h5D4000_4_0040_FF7F_FF_FF_C1_FF7F,
    100'h800000_2_00F0_0000_FF_FF_81_0000,
    100'h1C3412_5_1234_4000_FF_FF_41_4000,
    100'h9D6000_6_0060_FFFF_FF_FF_43_0000,
    100'hBD6000_6_0060_0000_FF_FF_C1_FFFF,
    100'h2B0700_2_00F0_0000_7F_FF_C1_0000,
    100'h2B0000_2_00F0_0000_7E_FF_C1_0000,
    100'hDD7000_5_0070_0000_7E_FF_C1_7EFF,
    100'h0B0000_2_00F0_0000_7F_FF_C1_0000,
    100'h1C3412_5_1234_8000_7F_FF_83_8000,
    100'h8B8070_4_0080_0800_7F_FF_82_0800,
    100'h6B8060_5_0080_0800_7F_FF_83_0800,
    100'hAB8060_5_0080_0800_7F_FF_82_0800,
    100'h6B8073_5_0380_0000_7F_FF_83_0000,
    100'hAB8073_5_0380_0000_7F_FF_82_0000,
    100'hCB8050_4_0080_0800_7F_FF_83_0800,
    100'h8B8000_4_0080_0800_7F_FF_82_0800,
    100'hCB8060_4_0080_0800_7F_FF_83_0800,
    100'h4B8070_5_0080_0800_7F_FF_83_0000,
    100'hEB8020_6_0080_0000_7F_FF_83_0200,
    100'hA19000_4_0090_0000_7F_FF_83_2000,
    100'hB19000_4_0090_FFFF_7F_FF_83_DFFF,
    100'h5C4523_6_2345_0F00_7F_FF_01_0000,
    100'h3C4523_6_2345_8000_7F_FF_81_FF00,
    100'h3C4523_6_2345_7F00_7F_FF_03_7F00,
    100'h200000_2_00F0_0000_7F_FF_02_0000,
    100'hA00000_2_00F0_0000_7F_FF_03_0000,
    100'hC00000_2_00F0_0000_7F_FF_23_0000,
    100'h7D1000_5_0110_AA55_AA_55_21_AA55,
    100'h400000_2_00F0_0000_AA_55_01_0000,
    100'hFF0000_1_00F0_0000_AA_55_01_0000
  };

  // ----------------------------
  // tasks
  // ----------------------------
  // entered just after a rising edge with the core idle
  task automatic run(input wbo_row_s r);
    int k;
    i_mem.mem[r.pa] = r.p0;
    i_mem.mem[r.pa + 16'h0001] = r.p1;
    i_instr <= r.ins;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    k = 0;
    do
    begin
      @(negedge i_clk);
      k++;
    end while (o_done !== 1'b1 && k < 20);
    `CHK("cycles", r.n, k)
    `CHK("illegal", r.n == 4'h1, o_illegal)
    @(posedge i_clk);
    @(negedge i_clk);
    `CHK("acc", r.ea, o_acc)
    `CHK("yreg", r.ey, o_yreg)
    `CHK("psw", r.ep, o_psw)
    `CHK("mem lo", r.e0, i_mem.mem[r.pa])
    `CHK("mem hi", r.e1, i_mem.mem[r.pa + 16'h0001])
    @(posedge i_clk);
  endtask

  task automatic stop_test;
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------
  // sequence
  // ----------------------------
  initial
  begin
    int d;
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    foreach (rows[i])
    begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    // start held high: ignored while busy, taken again right after done
    i_mem.mem[16'h00A0] = 8'hFE;
    i_mem.mem[16'h00A1] = 8'hFF;
    i_instr <= 24'h9DA000;
    i_start <= 1'b1;
    d = 0;
    for (int k = 1; k <= 13; k++)
    begin
      @(posedge i_clk);
      if (k == 8)
        i_start <= 1'b0;
      @(negedge i_clk);
      if (o_done === 1'b1)
        d++;
    end
    @(posedge i_clk);
    @(negedge i_clk);
    `CHK("done count", 2, d)
    `CHK("inc lo", 8'h00, i_mem.mem[16'h00A0])
    `CHK("inc hi", 8'h00, i_mem.mem[16'h00A1])
    `CHK("psw", 8'h03, o_psw)
    $display("back to back done");
    // reset in the middle of a word load
    @(posedge i_clk);
    i_instr <= 24'h7D1000;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    @(posedge i_clk);
    i_nrst <= 1'b0;
    @(negedge i_clk);
    `CHK("ready", 1'b1, o_ready)
    `CHK("mem req", 26'h0, o_mem)
    `CHK("pair", 16'h0000, {o_yreg, o_acc})
    `CHK("psw", 8'h00, o_psw)
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    run(100'hA00000_2_00F0_0000_00_00_01_0000);
    $display("reset test done");
    stop_test;
  end

  initial
  begin
    repeat (3000) @(posedge i_clk);
    miscompares++;
    $display("watchdog expired");
    stop_test;
  end
endmodule

`default_nettype wire
